// ===== design/pdp_pwm_top.sv
// top of the 14-bit pulse-division pwm: apb registers, prescaler, pin select
// Functional notes
// (RL1) period select 0: 16384 clocks, 1-clock step; 1: 32768 clocks, 2-clock step
// (RL2) control bits 7..1 reserved: read as 1, writes ignored
// (RL3) period select is write-only and always reads as 1
// (RL4) control register resets to fe hex, short period
// (RL5) duty is 14 bits: upper register 6 bits, lower register 8 bits
// (RL6) writing the upper register latches all 14 bits into the generator
// (RL7) software writes lower first, then upper
// (RL8) both duty registers are write-only and read as all ones
// (RL9) duty registers reset to c000 hex: upper c0, lower 00
// (RL10) one conversion period is 64 pulses sharing the high time
// (RL11) total high time is (duty + 64) times half the input clock period
// (RL12) shared pin carries pwm only while the port function bit is set
// (RL13) a latched duty takes effect at the next period start; one latched on the edge where the generator loads an older one is dropped
`timescale 1ns/1ps
`default_nettype none
module pdp_pwm_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic gpioOut,
	input wire logic gpioOe,
	output logic sharedOutputPin,
	output logic sharedOutputPinOe
);

	// register state
	logic [7:0] controlReg;
	logic [7:0] dutyUpper;
	logic [7:0] dutyLower;
	logic portFunctionSelect;

	// latch toward the generator
	pdp_pkg::pdp_duty_type pendingDuty;
	logic pending;

	// prescaler
	logic divPhase;
	logic stepEn;

	// generator outputs
	logic wave;
	logic loadTaken;
	logic [5:0] pulseIdx;

	// bus decode
	logic [17:0] regIdx;
	logic aligned;
	logic hitControl;
	logic hitUpper;
	logic hitLower;
	logic hitPort;
	logic hitStatus;
	logic hitAny;
	logic setupPhase;
	logic wrTake;
	logic rdTake;
	logic laneLow;
	logic [31:0] next_prdata;
	logic next_pslverr;
	pdp_pkg::pdp_status_type status;

	assign regIdx = paddr[19:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign hitControl = aligned && (regIdx == pdp_pkg::PDP_IDX_CLOCK_CONTROL);
	assign hitUpper = aligned && (regIdx == pdp_pkg::PDP_IDX_DUTY_UPPER);
	assign hitLower = aligned && (regIdx == pdp_pkg::PDP_IDX_DUTY_LOWER);
	assign hitPort = aligned && (regIdx == pdp_pkg::PDP_IDX_PORT_FUNCTION);
	assign hitStatus = aligned && (regIdx == pdp_pkg::PDP_IDX_STATUS);
	assign hitAny = hitControl || hitUpper || hitLower || hitPort || hitStatus;

	// the answer is prepared in the setup cycle and shown in the first access cycle
	assign setupPhase = psel && !penable;
	// writes take effect at the edge where the completed access is sampled
	assign wrTake = psel && penable && pready && pwrite && hitAny;
	assign rdTake = setupPhase && !pwrite;
	// writable registers are at most eight bits wide (status reads back 9 bits); a write with lane 0 strobed off is ignored
	assign laneLow = pstrb[0];

	assign status.pending = pending;
	assign status.periodSelect = controlReg[pdp_pkg::PDP_PERIOD_SELECT_BIT];
	assign status.wave = wave;
	assign status.pulseIdx = pulseIdx;

	// apb ready: one access cycle per transfer, no further wait states
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
		end else begin
			pready <= setupPhase;
		end
	end

	// read data and error answer
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (!hitAny) begin
			next_pslverr = 1'b1;
		end else if (rdTake) begin
			if (hitControl) begin
				next_prdata = {24'h00_0000, pdp_pkg::PDP_READ_ALL_ONES}; // RL2 RL3
			end else if (hitUpper || hitLower) begin
				next_prdata = {24'h00_0000, pdp_pkg::PDP_READ_ALL_ONES}; // RL8
			end else if (hitPort) begin
				next_prdata = {31'h0000_0000, portFunctionSelect};
			end else begin
				next_prdata = {23'h00_0000, status};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end else if (pready) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// control register: only the period select bit is writable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			controlReg <= pdp_pkg::PDP_RST_CLOCK_CONTROL; // RL4
		end else if (wrTake && hitControl && laneLow) begin
			controlReg[pdp_pkg::PDP_PERIOD_SELECT_BIT] <= pwdata[0]; // RL1 RL2
		end
	end

	// lower duty register holds its bits until the upper write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dutyLower <= pdp_pkg::PDP_RST_DUTY_LOWER; // RL9
		end else if (wrTake && hitLower && laneLow) begin
			dutyLower <= pwdata[7:0]; // RL5
		end
	end

	// upper duty register; bits 7..6 stay at one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dutyUpper <= pdp_pkg::PDP_RST_DUTY_UPPER; // RL9
		end else if (wrTake && hitUpper && laneLow) begin
			dutyUpper <= {2'b11, pwdata[5:0]}; // RL5
		end
	end

	// an upper write captures both halves; the order lower-then-upper is up to software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pendingDuty <= '0;
		end else if (wrTake && hitUpper && laneLow) begin
			pendingDuty.upper <= pwdata[5:0]; // RL6 RL7
			pendingDuty.lower <= dutyLower; // RL6
		end
	end

	// an upper write in the loadTaken cycle wins over the clear; one on the edge where the generator takes the old one is lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pending <= 1'b0;
		end else if (wrTake && hitUpper && laneLow) begin
			pending <= 1'b1; // RL6
		end else if (loadTaken) begin
			pending <= 1'b0; // RL13
		end
	end

	// port function select
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			portFunctionSelect <= 1'b0;
		end else if (wrTake && hitPort && laneLow) begin
			portFunctionSelect <= pwdata[pdp_pkg::PDP_PORT_FUNCTION_BIT];
		end
	end

	// prescaler: a step is half the input clock period, one or two system clocks
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divPhase <= 1'b0;
		end else begin
			divPhase <= !divPhase;
		end
	end

	assign stepEn = !controlReg[pdp_pkg::PDP_PERIOD_SELECT_BIT] || divPhase; // RL1 RL11

	// the generator sees a pending load only after the capture has settled
	pdp_wave_gen u_wave (
		.clk(clk),
		.rst_b(rst_b),
		.stepEn(stepEn),
		.loadReq(pending),
		.loadDuty(pendingDuty),
		.wave(wave),
		.periodStart(),
		.loadTaken(loadTaken),
		.pulseIdx(pulseIdx)
	);

	// shared pin: pwm while selected, otherwise the general port
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sharedOutputPin <= 1'b0;
			sharedOutputPinOe <= 1'b0;
		end else if (portFunctionSelect) begin
			sharedOutputPin <= wave; // RL12
			sharedOutputPinOe <= 1'b1; // RL12
		end else begin
			sharedOutputPin <= gpioOut;
			sharedOutputPinOe <= gpioOe;
		end
	end

endmodule : pdp_pwm_top
`default_nettype wire

// ===== design/pdp_wave_gen.sv
// pulse-division waveform generator: 64 pulses per period, remainder spread by bit reversal
`timescale 1ns/1ps
`default_nettype none
module pdp_wave_gen (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic stepEn,
	input wire logic loadReq,
	input wire pdp_pkg::pdp_duty_type loadDuty,
	output logic wave,
	output logic periodStart,
	output logic loadTaken,
	output logic [5:0] pulseIdx
);
	logic [13:0] stepCnt;
	logic [13:0] duty;
	logic [5:0] revIdx;
	logic [8:0] highSteps;
	logic extra;

	// reversed pulse index spreads the low six bits evenly over the period
	genvar i;
	generate
		for (i = 0; i < pdp_pkg::PDP_PULSE_IDX_W; i++) begin : g_rev
			assign revIdx[i] = stepCnt[13 - i];
		end
	endgenerate

	assign extra = (revIdx < duty[5:0]);
	// one step per pulse carries the +64 offset of the high time
	assign highSteps = {1'b0, duty[13:6]} + pdp_pkg::PDP_DUTY_OFFSET_STEPS + {8'h00, extra}; // RL11

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stepCnt <= 14'h0000;
		end else if (stepEn) begin
			stepCnt <= stepCnt + 14'h0001; // RL10
		end
	end

	// new duty only at a period boundary, so no period mixes two values
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			duty <= pdp_pkg::PDP_RST_DUTY; // RL9
			loadTaken <= 1'b0;
		end else begin
			loadTaken <= 1'b0;
			if (stepEn && stepCnt == 14'h3fff && loadReq) begin
				duty <= loadDuty; // RL13
				loadTaken <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wave <= 1'b0;
			periodStart <= 1'b0;
			pulseIdx <= 6'h00;
		end else begin
			wave <= ({1'b0, stepCnt[7:0]} < highSteps); // RL10
			periodStart <= stepEn && (stepCnt == 14'h0000);
			pulseIdx <= stepCnt[13:8];
		end
	end

endmodule : pdp_wave_gen
`default_nettype wire

// ===== dv/pdp_filter_model.sv
// low-pass filter stand-in: integrates high time and rising edges on the pin
`timescale 1ns/1ps
`default_nettype none
module pdp_filter_model (
	input wire logic clk,
	input wire logic pin,
	input wire logic oe,
	input wire logic clr,
	output logic [31:0] highCnt,
	output logic [31:0] rises
);
	logic last;
	// the first sample of a window is held against the real pin level, so a rise on it counts
	always_ff @(posedge clk) begin
		if (clr) begin
			highCnt <= 32'h0000_0000;
			rises <= 32'h0000_0000;
			last <= pin;
		end else begin
			highCnt <= highCnt + 32'(oe && pin);
			rises <= rises + 32'(oe && pin && !last);
			last <= pin;
		end
	end
endmodule : pdp_filter_model
`default_nettype wire

// ===== dv/pdp_pwm_asserts.sv
// port checker for the pulse-division pwm top
`timescale 1ns/1ps
`default_nettype none
module pdp_pwm_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic gpioOut,
	input wire logic gpioOe,
	input wire logic sharedOutputPin,
	input wire logic sharedOutputPinOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic fnSel;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			fnSel <= 1'h0;
		else if (psel && penable && pready && pwrite && pstrb[0] && !pslverr
			&& paddr == {pdp_pkg::PDP_IDX_PORT_FUNCTION, 2'h0})
			fnSel <= pwdata[0];
	end
	sequence setupS;
		psel && !penable;
	endsequence
	sequence readS(idx);
		psel && penable && pready && !pwrite && paddr == {idx, 2'h0};
	endsequence
	apb_answer_a: assert property (setupS |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
		else $error("answer outside access cycle");
	ctrl_read_a: assert property (readS(pdp_pkg::PDP_IDX_CLOCK_CONTROL)
		|-> prdata == 32'h0000_00ff) else $error("control read not ff");
	upper_read_a: assert property (readS(pdp_pkg::PDP_IDX_DUTY_UPPER)
		|-> prdata == 32'h0000_00ff) else $error("upper read not ff");
	lower_read_a: assert property (readS(pdp_pkg::PDP_IDX_DUTY_LOWER)
		|-> prdata == 32'h0000_00ff) else $error("lower read not ff");
	bad_addr_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	pin_gpio_a: assert property ($past(rst_b) && !$past(fnSel)
		|-> sharedOutputPin == $past(gpioOut) && sharedOutputPinOe == $past(gpioOe))
		else $error("pin not following port");
	pin_pwm_oe_a: assert property ($past(rst_b) && $past(fnSel) |-> sharedOutputPinOe)
		else $error("pin not driven in pwm mode");
endmodule : pdp_pwm_asserts
bind pdp_pwm_top pdp_pwm_asserts chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .pready, .prdata, .pslverr, .gpioOut, .gpioOe, .sharedOutputPin,
	.sharedOutputPinOe);
`default_nettype wire

// ===== dv/test_pulse_division_pwm_14bit.sv
// self-checking bench for the pulse-division pwm
`timescale 1ns/1ps
`default_nettype none
module test_pulse_division_pwm_14bit;
	logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [19:0] paddr = 20'h0_0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r, highCnt, rises;
	logic [3:0] pstrb = 4'hf;
	logic [1:0] offs = 2'h0;
	logic pready, pslverr, gpioOut = 1'h0, gpioOe = 1'h0, pin, pinOe, e, clr = 1'h0;
	logic [13:0] duty;
	int seed = 32'ha8fe566c, failures = 0, samplesChecked = 0, n;
	logic [17:0] regs [3] = '{pdp_pkg::PDP_IDX_CLOCK_CONTROL, pdp_pkg::PDP_IDX_DUTY_UPPER,
		pdp_pkg::PDP_IDX_DUTY_LOWER};
	always #10 clk = ~clk;
	pdp_pwm_top DUT (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .gpioOut, .gpioOe, .sharedOutputPin(pin),
		.sharedOutputPinOe(pinOe));
	pdp_filter_model lpf (.clk, .pin, .oe(pinOe), .clr, .highCnt, .rises);
	always @(posedge clk) {gpioOut, gpioOe} <= 2'($random(seed));
	function automatic logic [31:0] highExp(input logic [13:0] d, input logic sel);
		return ({18'h0_0000, d} + 32'h0000_0040) * (sel ? 32'h0000_0004 : 32'h0000_0002) / 2;
	endfunction : highExp
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// no wait limit here: only the watchdog ends a hung access
	task automatic apb(input logic w, input logic [17:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {idx, offs};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// window of whole periods, so the pin phase at its start does not matter
	task automatic meas(input int cyc);
		@(posedge clk);
		clr <= 1'h1;
		@(posedge clk);
		clr <= 1'h0;
		repeat (cyc) @(posedge clk);
		#1;
	endtask : meas
	task automatic conclude();
		$display("checks %0d failures %0d", samplesChecked, failures);
		if (failures == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		foreach (regs[i]) begin
			apb(1'h0, regs[i], 32'h0000_0000);
			chk(r, 32'h0000_00ff);
		end
		apb(1'h0, pdp_pkg::PDP_IDX_STATUS, 32'h0000_0000);
		chk(32'(r[8:7]), 32'h0000_0000);
		apb(1'h1, pdp_pkg::PDP_IDX_CLOCK_CONTROL, 32'h0000_0000);
		apb(1'h0, pdp_pkg::PDP_IDX_CLOCK_CONTROL, 32'h0000_0000);
		chk(r, 32'h0000_00ff);
		apb(1'h0, 18'h0_ffd3, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001);
		apb(1'h1, pdp_pkg::PDP_IDX_PORT_FUNCTION, 32'h0000_0001);
		apb(1'h1, pdp_pkg::PDP_IDX_CLOCK_CONTROL, 32'h0000_0001);
		apb(1'h0, pdp_pkg::PDP_IDX_STATUS, 32'h0000_0000);
		chk(32'(r[7]), 32'h0000_0001);
		// an unaligned write and a write with lane 0 off must both leave the select alone
		offs = 2'h2;
		apb(1'h1, pdp_pkg::PDP_IDX_CLOCK_CONTROL, 32'h0000_0000);
		offs = 2'h0;
		chk(32'(e), 32'h0000_0001);
		pstrb <= 4'he;
		apb(1'h1, pdp_pkg::PDP_IDX_CLOCK_CONTROL, 32'h0000_0000);
		pstrb <= 4'hf;
		apb(1'h0, pdp_pkg::PDP_IDX_STATUS, 32'h0000_0000);
		chk(32'(r[7]), 32'h0000_0001);
		meas(32768);
		chk(highCnt, highExp(14'h0000, 1'h1));
		chk(rises, 32'h0000_0040);
		// upper byte capped so no pulse fills its whole slot
		duty = 14'($random(seed)) & 14'h3eff;
		apb(1'h1, pdp_pkg::PDP_IDX_CLOCK_CONTROL, 32'h0000_0000);
		apb(1'h1, pdp_pkg::PDP_IDX_DUTY_LOWER, {24'h00_0000, duty[7:0]});
		apb(1'h0, pdp_pkg::PDP_IDX_STATUS, 32'h0000_0000);
		chk(32'(r[8]), 32'h0000_0000);
		apb(1'h1, pdp_pkg::PDP_IDX_DUTY_UPPER, {26'h000_0000, duty[13:8]});
		apb(1'h0, pdp_pkg::PDP_IDX_STATUS, 32'h0000_0000);
		chk(32'(r[8]), 32'h0000_0001);
		n = 0;
		while (r[8] !== 1'h0 && n < 8000) begin
			apb(1'h0, pdp_pkg::PDP_IDX_STATUS, 32'h0000_0000);
			n++;
		end
		chk(32'(r[8]), 32'h0000_0000);
		meas(16384);
		chk(highCnt, highExp(duty, 1'h0));
		chk(rises, 32'h0000_0040);
		conclude();
	end
endmodule : test_pulse_division_pwm_14bit
`default_nettype wire

// ===== include/pdp_pkg.sv
// package for the pulse-division pwm: register map, reset values and carriers
package pdp_pkg;

	localparam int PDP_ADDR_W = 20;
	localparam int PDP_DATA_W = 32;
	localparam int PDP_DUTY_W = 14;

	// register indexes; the byte address is four times the index
	localparam logic [17:0] PDP_IDX_CLOCK_CONTROL = 18'h0_ffd0;
	localparam logic [17:0] PDP_IDX_DUTY_UPPER = 18'h0_ffd1;
	localparam logic [17:0] PDP_IDX_DUTY_LOWER = 18'h0_ffd2;
	localparam logic [17:0] PDP_IDX_PORT_FUNCTION = 18'h0_ffd4;
	localparam logic [17:0] PDP_IDX_STATUS = 18'h0_ffd5;

	// reset values
	localparam logic [7:0] PDP_RST_CLOCK_CONTROL = 8'hfe;
	localparam logic [7:0] PDP_RST_DUTY_UPPER = 8'hc0;
	localparam logic [7:0] PDP_RST_DUTY_LOWER = 8'h00;
	localparam logic [13:0] PDP_RST_DUTY = 14'h0000;

	// read values of write-only registers
	localparam logic [7:0] PDP_READ_ALL_ONES = 8'hff;

	// field positions
	localparam int PDP_PERIOD_SELECT_BIT = 0;
	localparam int PDP_PORT_FUNCTION_BIT = 0;
	localparam int PDP_UPPER_W = 6;
	localparam int PDP_LOWER_W = 8;

	// waveform geometry: 64 pulses of 256 steps each per period
	localparam int PDP_PULSE_IDX_W = 6;
	localparam int PDP_PULSE_POS_W = 8;
	localparam logic [8:0] PDP_DUTY_OFFSET_STEPS = 9'h001;

	// apb answer in the cycle after setup
	localparam int PDP_APB_WAIT_CYCLES = 0;

	typedef struct packed {
		logic [5:0] upper;
		logic [7:0] lower;
	} pdp_duty_type;

	typedef struct packed {
		logic pending;
		logic periodSelect;
		logic wave;
		logic [5:0] pulseIdx;
	} pdp_status_type;

endpackage : pdp_pkg
